//--- src/exec_core.sv
// Purpose: Executes table write, zero-test skip and XOR instructions for an 8-bit core.
// Assumes: The fetch stage presents one instruction per cycle and honours busy and flush.
// Notes: File register data arrives combinationally on file_rdata for the addressed register.
`timescale 1ns/10ps
module exec_core (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire exec_pkg::issue_type issue,
  output logic busy,
  output logic flush,
  output logic return_req,
  output exec_pkg::file_req_type file_req,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] bank_select_register,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [31:0] ctrl_reg;
  logic [exec_pkg::PTR_W-1:0] table_pointer_reg;
  logic [7:0] table_latch_reg;
  logic [7:0] wreg_reg;
  logic neg_reg;
  logic zero_reg;
  logic [11:0] ptr2_reg;
  logic [11:0] ptr0_reg;
  logic [11:0] ptr1_reg;
  exec_pkg::exec_state_type state_reg;
  logic [1:0] tw_mode_reg;
  logic hold_we;
  logic [7:0] hold_rdata;
  logic [2:0] hold_raddr;
  logic ext_en;
  logic run;
  logic [15:0] op;
  logic is_table_write_op;
  logic is_test_file_skip_op;
  logic is_xor_literal_op;
  logic is_xor_file_op;
  logic is_pointer_add_literal_op;
  logic is_pointer_subtract_literal_op;
  logic [7:0] f_addr;
  logic acc_bit;
  logic dest_bit;
  logic [7:0] xor_res;
  logic apb_wr;
  logic apb_rd;
  logic [11:0] eff_addr;
  logic indexed;
  logic [exec_pkg::PTR_W-1:0] ptr_pre;
  logic hold_rd;
  logic hold_wait_reg;

  assign ext_en = ctrl_reg[exec_pkg::CTRL_XEN_BIT];
  assign run = (state_reg == exec_pkg::ST_RUN) && issue.valid;
  assign op = issue.word;
  assign f_addr = op[7:0];
  assign acc_bit = op[8];
  assign dest_bit = op[9];
  assign is_table_write_op = (op[15:2] == 14'h0003);
  assign is_test_file_skip_op = (op[15:9] == 7'h33);
  assign is_xor_literal_op = (op[15:8] == 8'h0A);
  assign is_xor_file_op = (op[15:10] == 6'h06);
  // The pointer-literal group decodes only with the extension on; otherwise these codes are left alone.
  assign is_pointer_add_literal_op = ext_en && (op[15:8] == 8'hE8);
  assign is_pointer_subtract_literal_op = ext_en && (op[15:8] == 8'hE9);
  assign indexed = !acc_bit && ext_en && (f_addr <= exec_pkg::LOW_OFFSET_MAX);

  // Address generation for byte-oriented file operands.
  always_comb
  begin
    if (indexed)
      eff_addr = ptr2_reg + {4'h0, f_addr};
    else if (acc_bit)
      eff_addr = {bank_select_register[3:0], f_addr};
    else if ({4'h0, f_addr} < exec_pkg::ACCESS_SPLIT)
      eff_addr = {4'h0, f_addr};
    else
      eff_addr = exec_pkg::ACCESS_HIGH_BASE | {4'h0, f_addr};
  end

  assign xor_res = is_xor_literal_op ? (wreg_reg ^ f_addr) : (wreg_reg ^ file_rdata);

  always_comb
  begin
    file_req.addr = eff_addr;
    file_req.ind = indexed;
    file_req.wdata = xor_res;
    file_req.we = run && is_xor_file_op && dest_bit;
  end

  assign busy = (state_reg != exec_pkg::ST_RUN) || (run && (is_table_write_op || (is_test_file_skip_op && file_rdata == 8'h00)));
  assign flush = run && is_test_file_skip_op && (file_rdata == 8'h00);

  // Table pointer: pre-increment lands at once so the second cycle writes the new slot.
  always_comb
  begin
    ptr_pre = table_pointer_reg;
    if (run && is_table_write_op && op[1:0] == exec_pkg::TW_PREINC)
      ptr_pre = table_pointer_reg + 21'h000001;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= exec_pkg::ST_RUN;
    else
    begin
      unique case (state_reg)
        exec_pkg::ST_RUN:
        begin
          if (run && is_table_write_op)
            state_reg <= exec_pkg::ST_TBLWT2;
          else if (run && is_test_file_skip_op && file_rdata == 8'h00)
            state_reg <= issue.next_two_word ? exec_pkg::ST_SKIP2 : exec_pkg::ST_SKIP1;
        end
        exec_pkg::ST_TBLWT2: state_reg <= exec_pkg::ST_RUN;
        exec_pkg::ST_SKIP1: state_reg <= exec_pkg::ST_RUN;
        exec_pkg::ST_SKIP2: state_reg <= exec_pkg::ST_SKIP1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      tw_mode_reg <= exec_pkg::TW_NOCHG;
    else if (run && is_table_write_op)
      tw_mode_reg <= op[1:0];
  end

  assign hold_we = (state_reg == exec_pkg::ST_TBLWT2);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      table_pointer_reg <= '0;
    else if (run && is_table_write_op)
      table_pointer_reg <= ptr_pre;
    else if (hold_we && tw_mode_reg == exec_pkg::TW_POSTINC)
      table_pointer_reg <= table_pointer_reg + 21'h000001;
    else if (hold_we && tw_mode_reg == exec_pkg::TW_POSTDEC)
      table_pointer_reg <= table_pointer_reg - 21'h000001;
    else if (apb_wr && paddr == exec_pkg::REG_TABLE_POINTER)
      table_pointer_reg <= pwdata[exec_pkg::PTR_W-1:0];
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wreg_reg <= 8'h00;
      neg_reg <= 1'b0;
      zero_reg <= 1'b0;
    end
    else if (run && (is_xor_literal_op || is_xor_file_op))
    begin
      if (is_xor_literal_op || !dest_bit)
        wreg_reg <= xor_res;
      neg_reg <= xor_res[7];
      zero_reg <= (xor_res == 8'h00);
    end
    else if (apb_wr && paddr == exec_pkg::REG_WREG)
      wreg_reg <= pwdata[7:0];
  end

  // The second pointer serves indexed mode and the returning pointer ops; the others only track arithmetic.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ptr0_reg <= 12'h000;
      ptr1_reg <= 12'h000;
      ptr2_reg <= 12'h000;
    end
    else if (run && (is_pointer_add_literal_op || is_pointer_subtract_literal_op))
    begin
      unique case (op[7:6])
        2'h0: ptr0_reg <= is_pointer_add_literal_op ? ptr0_reg + {6'h00, op[5:0]} : ptr0_reg - {6'h00, op[5:0]};
        2'h1: ptr1_reg <= is_pointer_add_literal_op ? ptr1_reg + {6'h00, op[5:0]} : ptr1_reg - {6'h00, op[5:0]};
        default: ptr2_reg <= is_pointer_add_literal_op ? ptr2_reg + {6'h00, op[5:0]} : ptr2_reg - {6'h00, op[5:0]};
      endcase
    end
    else if (apb_wr && paddr == exec_pkg::REG_PTR2)
      ptr2_reg <= pwdata[11:0];
  end

  // Return request pulses for the fixed second-pointer variants; the fetch stage does the stack pop.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      return_req <= 1'b0;
    else
      return_req <= run && (is_pointer_add_literal_op || is_pointer_subtract_literal_op) && (op[7:6] == 2'h3);
  end

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  // Holding bytes come out of a registered memory, so their reads take one wait state.
  assign hold_rd = psel && penable && !pwrite && paddr[11:5] == exec_pkg::REG_HOLD_BASE[11:5];
  assign pready = !hold_rd || hold_wait_reg;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      hold_wait_reg <= 1'b0;
    else
      hold_wait_reg <= hold_rd && !hold_wait_reg;
  end
  assign pslverr = 1'b0;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= exec_pkg::CTRL_RESET;
      table_latch_reg <= 8'h00;
    end
    else if (apb_wr && paddr == exec_pkg::REG_CTRL)
      ctrl_reg <= {31'h0, pwdata[exec_pkg::CTRL_XEN_BIT]};
    else if (apb_wr && paddr == exec_pkg::REG_LATCH)
      table_latch_reg <= pwdata[7:0];
  end

  assign hold_raddr = paddr[4:2];

  hold_mem #(
    .DEPTH(exec_pkg::HOLD_N)
  ) u_hold (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .we(hold_we),
    .waddr(table_pointer_reg[2:0]),
    .wdata(table_latch_reg),
    .raddr(hold_raddr),
    .rdata(hold_rdata)
  );

  // Register read data is prepared in the setup cycle; holding bytes are loaded at the end of the first access cycle, the wait state.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (apb_rd)
    begin
      unique case (paddr)
        exec_pkg::REG_CTRL: prdata <= ctrl_reg;
        exec_pkg::REG_TABLE_POINTER: prdata <= {11'h000, table_pointer_reg};
        exec_pkg::REG_LATCH: prdata <= {24'h000000, table_latch_reg};
        exec_pkg::REG_WREG: prdata <= {24'h000000, wreg_reg};
        exec_pkg::REG_STATUS: prdata <= {28'h0000000, state_reg != exec_pkg::ST_RUN, table_pointer_reg[0],
                                         neg_reg, zero_reg};
        exec_pkg::REG_PTR2: prdata <= {20'h00000, ptr2_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
    else if (hold_rd)
      prdata <= {24'h000000, hold_rdata};
  end
endmodule : exec_core

//--- inc/exec_pkg.sv
// Purpose: Shared constants and types for the table-write, zero-test skip and XOR execute block.
// Assumes: One 20 MHz system clock, one instruction issued per cycle by the fetch stage.
// Notes: Register offsets are byte addresses on a 32-bit APB slave.
// Functional notes
// - The two low opcode bits of a table write choose no change, post-increment, post-decrement or pre-increment.
// - A table write copies the table latch into the holding register picked by the three low pointer bits.
// - The table pointer is 21 bits wide and spans two megabytes of program memory bytes.
// - Pointer bit zero picks the low byte (0) or the high byte (1) of a program memory word.
// - The zero-test skip discards the next fetched instruction when the file value is zero, taking two cycles.
// - A taken skip over a two-word instruction adds one more idle cycle, three in total.
// - Access bit zero maps the file address into the access bank, one joins it with the bank select register.
// - With access bit zero, extension enabled and address up to 95, the operand is an indexed literal offset.
// - XOR with literal writes W xor k to W, sets negative and zero flags, in one cycle.
// - XOR with file sends W xor f to W when d is zero or to the file when d is one, updating N and Z.
// - The extension and indexed literal offset mode stay off unless the extension enable bit is set.
// - When enabled the extension adds eight pointer-literal instructions and indexed literal offset addressing.
// - The pointer add and subtract variants fixed to the second pointer also return from subroutine.
package exec_pkg;
  localparam int PTR_W = 21;
  localparam int HOLD_N = 8;
  localparam logic [7:0] LOW_OFFSET_MAX = 8'h5F;
  localparam logic [11:0] ACCESS_HIGH_BASE = 12'hF00;
  localparam logic [11:0] ACCESS_SPLIT = 12'h060;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TABLE_POINTER = 12'h004;
  localparam logic [11:0] REG_LATCH = 12'h008;
  localparam logic [11:0] REG_WREG = 12'h00C;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_PTR2 = 12'h014;
  localparam logic [11:0] REG_HOLD_BASE = 12'h020;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_XEN_BIT = 0;
  localparam logic [1:0] TW_NOCHG = 2'h0;
  localparam logic [1:0] TW_POSTINC = 2'h1;
  localparam logic [1:0] TW_POSTDEC = 2'h2;
  localparam logic [1:0] TW_PREINC = 2'h3;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic next_two_word;
  } issue_type;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic ind;
  } file_req_type;

  typedef enum logic [1:0] {ST_RUN, ST_TBLWT2, ST_SKIP1, ST_SKIP2} exec_state_type;
endpackage : exec_pkg

//--- src/hold_mem.sv
// Purpose: Eight-byte holding register bank for flash programming.
// Assumes: One write and one registered read port.
// Notes: Read data is registered, so reads lag the address by one clock.
`timescale 1ns/10ps
module hold_mem #(
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem_reg [DEPTH];

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= 8'hFF;
    end
    else if (we)
      mem_reg[waddr] <= wdata;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else
      rdata <= mem_reg[raddr];
  end
endmodule : hold_mem

//--- verif/exec_asserts.sv
// Purpose: Port checker for exec_core.
// Assumes: Bound to every exec_core instance.
// Notes: Mirrors the stall count and the extension bit from port activity.
`timescale 1ns/10ps
module exec_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire exec_pkg::issue_type issue,
  input wire logic busy,
  input wire logic flush,
  input wire logic return_req,
  input wire exec_pkg::file_req_type file_req,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] bank_select_register,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata
);
  logic xen_reg;
  logic [1:0] stall_reg;
  logic acc, tw, sk, xl, xf, ret;
  assign acc = issue.valid && stall_reg == 2'h0;
  assign tw = issue.word[15:2] == 14'h0003;
  assign sk = issue.word[15:9] == 7'h33;
  assign xl = issue.word[15:8] == 8'h0A;
  assign xf = issue.word[15:10] == 6'h06;
  assign ret = issue.word[15:9] == 7'h74 && issue.word[7:6] == 2'h3;
  // Own stall count, so busy is judged without seeing the core's state.
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      stall_reg <= 2'h0;
    else if (stall_reg != 2'h0)
      stall_reg <= stall_reg - 2'h1;
    else if (acc && tw)
      stall_reg <= 2'h1;
    else if (acc && sk && file_rdata == 8'h00)
      stall_reg <= issue.next_two_word ? 2'h2 : 2'h1;
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      xen_reg <= 1'b0;
    else if (psel && penable && pwrite && paddr == exec_pkg::REG_CTRL)
      xen_reg <= pwdata[exec_pkg::CTRL_XEN_BIT];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_TW_STALL: assert property (acc && tw |-> busy ##1 busy)
    else $error("table write not two cycles");
  AST_STALL: assert property (stall_reg != 2'h0 |-> busy)
    else $error("busy low in a stall cycle");
  AST_FLUSH: assert property (acc && sk |-> flush == (file_rdata == 8'h00))
    else $error("skip flush wrong");
  AST_XOR_1CYC: assert property (acc && (xl || xf) |-> !busy && !flush)
    else $error("xor stalled");
  AST_XOR_WE: assert property (acc && xf |-> file_req.we == issue.word[9])
    else $error("xor destination wrong");
  AST_BANK: assert property (acc && (xf || sk) && issue.word[8] |-> !file_req.ind &&
    file_req.addr == {bank_select_register[3:0], issue.word[7:0]})
    else $error("banked address wrong");
  AST_INDEXED: assert property (acc && (xf || sk) && !issue.word[8] |->
    file_req.ind == (xen_reg && issue.word[7:0] <= exec_pkg::LOW_OFFSET_MAX))
    else $error("indexed mode wrong");
  AST_RET: assert property (acc && ret |=> return_req == $past(xen_reg))
    else $error("return request wrong");
endmodule : exec_asserts
bind exec_core exec_asserts chk (.clk_sys, .sys_rst, .issue, .busy, .flush, .return_req, .file_req,
  .file_rdata, .bank_select_register, .psel, .penable, .pwrite, .paddr, .pwdata);

//--- verif/file_model.sv
// Purpose: Data register file behind exec_core.
// Assumes: Reads are combinational, writes land at the clock edge.
// Notes: The bench preloads only the bytes it uses.
`timescale 1ns/10ps
module file_model (
  input wire logic clk_sys,
  input wire exec_pkg::file_req_type file_req,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [4096];
  assign file_rdata = mem[file_req.addr];
  always @(posedge clk_sys)
    if (file_req.we)
      mem[file_req.addr] <= file_req.wdata;
endmodule : file_model

//--- verif/tb.sv
// Purpose: Self-checking bench for exec_core.
// Assumes: 20 MHz clock, reset held five cycles.
// Notes: Holding byte reads carry a wait state; the master waits for pready.
`timescale 1ns/10ps
module tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  exec_pkg::issue_type issue = '0;
  logic busy, flush, return_req, pready, pslverr, flushed, retd;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] file_rdata, bank_select_register = 8'h03;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  exec_pkg::file_req_type file_req;
  int failures = 0, n_tests = 0, stall;
  logic [1:0] md [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
  logic [7:0] lat [4] = '{8'h34, 8'h77, 8'h99, 8'h12};
  logic [31:0] pa [4] = '{32'h0, 32'h0, 32'h1FFFFF, 32'h0};
  logic [11:0] ha [4] = '{12'h020, 12'h020, 12'h020, 12'h03C};
  always #25 clk_sys = ~clk_sys;
  exec_core uut (.clk_sys, .sys_rst, .issue, .busy, .flush, .return_req, .file_req, .file_rdata,
    .bank_select_register, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  file_model fm (.clk_sys, .file_req, .file_rdata);
  task automatic complete_run;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang;
    failures++;
    complete_run();
  endtask : hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 9; n++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    if (n == 9)
      hang();
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, pslverr}, 32'h0);
  endtask : rchk
  // Counts the busy cycles after the accepting edge; a hung core ends the run.
  task automatic run(input logic [15:0] w, input logic two);
    @(posedge clk_sys);
    issue <= '{1'b1, w, two};
    #1 flushed = flush;
    @(posedge clk_sys);
    issue.valid <= 1'b0;
    #1 retd = return_req;
    stall = 0;
    while (busy === 1'b1 && stall < 9)
    begin
      @(posedge clk_sys);
      #1 stall++;
    end
    if (stall == 9)
      hang();
  endtask : run
  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rchk(exec_pkg::REG_CTRL, exec_pkg::CTRL_RESET);
    rchk(12'h040, 32'h0);
    apb(1'b1, exec_pkg::REG_WREG, 32'hB5);
    run(16'h0AAF, 1'b0);
    chk(stall, 0);
    rchk(exec_pkg::REG_WREG, 32'h1A);
    run(16'h0A1A, 1'b0);
    rchk(exec_pkg::REG_STATUS, 32'h1);
    apb(1'b1, exec_pkg::REG_WREG, 32'hB5);
    fm.mem[12'h020] <= 8'hAF;
    fm.mem[12'h310] <= 8'h0F;
    fm.mem[12'hF80] <= 8'hBA;
    run(16'h1A20, 1'b0);
    chk(fm.mem[12'h020], 32'h1A);
    rchk(exec_pkg::REG_WREG, 32'hB5);
    run(16'h1910, 1'b0);
    rchk(exec_pkg::REG_WREG, 32'hBA);
    rchk(exec_pkg::REG_STATUS, 32'h2);
    run(16'h1880, 1'b0);
    rchk(exec_pkg::REG_STATUS, 32'h1);
    apb(1'b1, exec_pkg::REG_TABLE_POINTER, 32'hFFFFFFFF);
    rchk(exec_pkg::REG_TABLE_POINTER, 32'h1FFFFF);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, exec_pkg::REG_LATCH, {24'h0, lat[i]});
      run({14'h0003, md[i]}, 1'b0);
      chk(stall, 1);
      rchk(exec_pkg::REG_TABLE_POINTER, pa[i]);
      apb(1'b0, exec_pkg::REG_STATUS, 32'h0);
      chk(rd & 32'h4, {29'h0, pa[i][0], 2'h0});
      apb(1'b0, ha[i], 32'h0);
      rchk(ha[i], {24'h0, lat[i]});
    end
    apb(1'b1, exec_pkg::REG_PTR2, 32'h100);
    fm.mem[12'h040] <= 8'h05;
    fm.mem[12'h140] <= 8'h00;
    fm.mem[12'h311] <= 8'h00;
    run(16'h6640, 1'b1);
    chk(32'(flushed), 32'h0);
    chk(stall, 0);
    apb(1'b1, exec_pkg::REG_CTRL, 32'h1);
    run(16'h6640, 1'b1);
    chk(32'(flushed), 32'h1);
    chk(stall, 2);
    run(16'h6711, 1'b0);
    chk(stall, 1);
    run(16'hE8C5, 1'b0);
    chk(32'(retd), 32'h1);
    rchk(exec_pkg::REG_PTR2, 32'h105);
    run(16'hE9C3, 1'b0);
    chk(32'(retd), 32'h1);
    rchk(exec_pkg::REG_PTR2, 32'h102);
    apb(1'b1, exec_pkg::REG_CTRL, 32'h0);
    run(16'hE8C5, 1'b0);
    chk(32'(retd), 32'h0);
    rchk(exec_pkg::REG_PTR2, 32'h102);
    complete_run();
  end
endmodule : tb
